// ---- design/csm_cfg_bank.sv ----
// Config-space slice: subsystem ids, MSI-X capability and programmable BAR window setup.
// Overview of operation
// R1: Subsystem header reads id 0Dh, next pointer B0h.
// R2: Read-only vendor code 15:0, device code 31:16, preloadable.
// R3: MSI-X header reads id 11h, next pointer C8h.
// R4: Table-size field 26:16 reports vectors minus one.
// R5: Function mask bit 30 masks every vector regardless of per-vector masks.
// R6: MSI-X allowed only with bit 31 set and MSI off; then INTx blocked.
// R7: Table locator reports BAR0 index 000b, offset default 0000_FE00h.
// R8: Pending-array locator reports BAR0, offset default 0000_FE10h.
// R9: Vendor header reads id 09h, next 00h, length 0038h.
// R10: BAR0 type: 00 off, 01 reserved, 10 32-bit, 11 64-bit pair.
// R11: BAR2/BAR4 bits 2:1: 00 32-bit, 10 64-bit pair; bit 3 prefetch.
// R12: Bit 4 steers hits: 0 lookup table, 1 direct base translation.
// R13: Software writes only domain numbers 0 to 11 into bits 8:5.
// R14: Size bits 30:20 make matching BAR address bits writable or zero.
// R15: Lookup window at least 1MB, split into 128 equal pages.
// R16: Bit 31 is enable in 32-bit mode, extra size bit in 64-bit mode.
// R17: Upper register in 32-bit mode is an independent BAR, type fixed 00b.
// R18: Upper register in 64-bit mode holds upper size; bit 31 enables pair.
// R19: BAR4/5 pair follows the same rules at F0h and F4h.
// R20: Reserved fields and slot registers read zero and ignore writes.
`timescale 1ns/1ps

module csm_cfg_bank
    import csm_pkg::*;
#(
    parameter int          MSIX_VECTORS      = 1,
    parameter logic [15:0] SUBSYS_VENDOR_RST = 16'h0a5a, // Arbitrary value.
    parameter logic [15:0] SUBSYS_DEVICE_RST = 16'h5a0a  // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Configuration access from the host.
    input  wire csm_cfg_req_s              cfgReq,
    output logic                           cfgAck,
    output logic [31:0]                    cfgRdata,
    // Nonvolatile preload (EEPROM or SMBus).
    input  wire csm_preload_s              preload,
    // Interrupt signalling controls.
    input  wire logic                      msiEnable,
    input  wire logic [MSIX_VECTORS-1:0]   vectorMask,
    output logic                           msixSendAllowed,
    output logic                           intxBlocked,
    output logic [MSIX_VECTORS-1:0]        vectorMasked,
    // Window setup toward the translation logic.
    output csm_window_s                    bar0Window,
    output csm_window_s [3:0]              pairWindows,
    // Inbound hit steering.
    input  wire logic                      hitValid,
    input  wire logic                      hitPair,
    input  wire logic [31:0]               hitOffset,
    output csm_hit_s                       hitResult
);

    // ========================================================================
    // Helpers.

    // Merge a write under byte enables and a per-register writable mask.
    function automatic logic [31:0] mergeWr(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
        return (old & ~bm) | (wd & bm);
    endfunction

    // Lowest writable address bit of a window, which sets its size.
    function automatic logic [5:0] lowBit(input logic [11:0] m);
        logic [5:0] k;
        k = CSM_NO_SIZE;
        for (int i = 11; i >= 0; i--) begin
            if (m[i]) begin
                k = 6'(CSM_SIZE_LSB + i);
            end
        end
        return k;
    endfunction

    // ========================================================================
    // Write path decode. Preload wins over a host write in the same cycle.
    logic        hostWr;
    logic        wrEn;
    logic [11:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrBe;
    logic        idsWr;
    logic        tblWr;
    logic        pendWr;
    logic        msixWr;
    logic        bar0Wr;

    assign hostWr = cfgReq.valid & cfgReq.write;
    assign wrEn   = preload.valid | hostWr;
    assign wrAddr = preload.valid ? preload.addr : cfgReq.addr;
    assign wrData = preload.valid ? preload.data : cfgReq.wdata;
    assign wrBe   = preload.valid ? 4'hf : cfgReq.byteEn;
    // Identifier and locator fields are read-only to the host, only preload moves them.
    assign idsWr  = preload.valid & (wrAddr[11:2] == CSM_OFF_SUBSYS_IDS[11:2]); // R2
    assign tblWr  = preload.valid & (wrAddr[11:2] == CSM_OFF_MSIX_TABLE[11:2]);
    assign pendWr = preload.valid & (wrAddr[11:2] == CSM_OFF_MSIX_PEND[11:2]);
    assign msixWr = wrEn & (wrAddr[11:2] == CSM_OFF_MSIX_CTL[11:2]);
    assign bar0Wr = wrEn & (wrAddr[11:2] == CSM_OFF_BAR0[11:2]);

    // ========================================================================
    // Identifier, MSI-X and BAR0 storage.
    logic [31:0] ids_q;
    logic [31:0] table_q;
    logic [31:0] pend_q;
    logic [31:0] msix_q;
    logic [31:0] bar0_q;

    // Locator writes keep bits 2:0 at zero so both always point at BAR0.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ids_q   <= {SUBSYS_DEVICE_RST, SUBSYS_VENDOR_RST};
            table_q <= CSM_RST_TABLE;
            pend_q  <= CSM_RST_PEND;
            msix_q  <= CSM_RST_MSIX;
            bar0_q  <= CSM_RST_BAR0;
        end else begin
            if (idsWr) ids_q <= mergeWr(ids_q, wrData, wrBe, CSM_WM_ALL);
            if (tblWr) table_q <= mergeWr(table_q, wrData, wrBe, CSM_WM_LOC);   // R7
            if (pendWr) pend_q <= mergeWr(pend_q, wrData, wrBe, CSM_WM_LOC);    // R8
            if (msixWr) msix_q <= mergeWr(msix_q, wrData, wrBe, CSM_WM_MSIX);
            if (bar0Wr) bar0_q <= mergeWr(bar0_q, wrData, wrBe, CSM_WM_BAR0);
        end
    end

    // ========================================================================
    // MSI-X signalling controls.
    logic fnMask;
    logic msixOn;

    assign fnMask          = msix_q[CSM_FNMASK_BIT];
    assign msixOn          = msix_q[CSM_MSIXEN_BIT];
    assign vectorMasked    = fnMask ? {MSIX_VECTORS{1'b1}} : vectorMask; // R5
    assign msixSendAllowed = msixOn & ~msiEnable;                        // R6
    assign intxBlocked     = msixOn & ~msiEnable;                        // R6

    // BAR0 decode; the reserved code 01b leaves the window off.
    assign bar0Window.enable   = (bar0_q[1:0] == CSM_BAR0_32) | (bar0_q[1:0] == CSM_BAR0_64); // R10
    assign bar0Window.is64     = bar0_q[1:0] == CSM_BAR0_64;                                  // R10
    assign bar0Window.prefetch = bar0_q[2];
    assign bar0Window.direct   = 1'b0;
    assign bar0Window.domain   = 4'h0;
    assign bar0Window.addrMask = 32'h00000000;

    // ========================================================================
    // BAR2/3 and BAR4/5 pairs share one structure.
    csm_window_s [3:0] winW;

    for (genvar p = 0; p < 2; p++) begin : g_pair
        localparam logic [11:0] LO_OFF = (p == 0) ? CSM_OFF_BAR2 : CSM_OFF_BAR4; // R19
        localparam logic [11:0] HI_OFF = (p == 0) ? CSM_OFF_BAR3 : CSM_OFF_BAR5; // R19
        logic [31:0] lo_q;
        logic [31:0] hi_q;
        logic        is64;
        logic [31:0] hiWm;
        logic [31:0] hiRd;
        logic        pairEn;
        logic        loWr;
        logic        hiWr;

        assign is64   = lo_q[2:1] == CSM_PAIR_64;           // R11
        assign hiWm   = is64 ? CSM_WM_HI64 : CSM_WM_HI32;    // R17 R18
        assign hiRd   = hi_q & hiWm;                         // R17
        assign pairEn = hi_q[CSM_EN_BIT];                    // R18
        assign loWr   = wrEn & (wrAddr[11:2] == LO_OFF[11:2]);
        assign hiWr   = wrEn & (wrAddr[11:2] == HI_OFF[11:2]);

        // Upper reserved bits written in 32-bit mode are dropped, so a later mode
        // change never exposes stale values.
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                lo_q <= CSM_RST_LO;
                hi_q <= CSM_RST_HI;
            end else begin
                if (loWr) lo_q <= mergeWr(lo_q, wrData, wrBe, CSM_WM_LO);
                if (hiWr) hi_q <= mergeWr(hi_q, wrData, wrBe, hiWm);  // R17 R18
            end
        end

        // Lower window: bit 31 enables alone, or joins the size mask when paired.
        assign winW[2*p].enable   = is64 ? pairEn : lo_q[CSM_EN_BIT];              // R16
        assign winW[2*p].is64     = is64;
        assign winW[2*p].prefetch = lo_q[CSM_PREF_BIT];                            // R11
        assign winW[2*p].direct   = lo_q[CSM_MODE_BIT];                            // R12
        assign winW[2*p].domain   = lo_q[CSM_DOM_LSB+3:CSM_DOM_LSB];
        assign winW[2*p].addrMask = (is64 ? {lo_q[31], lo_q[30:20], 20'h00000}     // R14 R16
                                          : {1'b1, lo_q[30:20], 20'h00000})
                                    & {32{winW[2*p].enable}};                      // R18
        // Upper window: an independent BAR, or the top half of the pair.
        assign winW[2*p+1].enable   = pairEn;                                      // R17 R18
        assign winW[2*p+1].is64     = is64;
        assign winW[2*p+1].prefetch = is64 ? lo_q[CSM_PREF_BIT] : hi_q[CSM_PREF_BIT];
        assign winW[2*p+1].direct   = is64 ? lo_q[CSM_MODE_BIT] : 1'b1;
        assign winW[2*p+1].domain   = is64 ? lo_q[CSM_DOM_LSB+3:CSM_DOM_LSB]
                                           : hi_q[CSM_DOM_LSB+3:CSM_DOM_LSB];
        assign winW[2*p+1].addrMask = (is64 ? {1'b1, hi_q[30:0]}                   // R18
                                            : {1'b1, hi_q[30:20], 20'h00000})      // R14 R17
                                      & {32{pairEn}};
    end

    assign pairWindows = winW;

    // ========================================================================
    // Inbound hit steering and lookup page index.
    logic        selEn;
    logic        selDirect;
    logic [31:0] selMask;
    logic [5:0]  winLsb;
    logic [5:0]  pageShift;
    logic [6:0]  pageIndex;
    csm_hit_s    hit_q;

    assign selEn     = hitPair ? winW[2].enable : winW[0].enable;
    assign selDirect = hitPair ? winW[2].direct : winW[0].direct;
    assign selMask   = hitPair ? winW[2].addrMask : winW[0].addrMask;
    // Size bits start at 20, so a window is never under 1MB and a page never under 8KB.
    assign winLsb    = lowBit(selMask[31:20]);                 // R15
    assign pageShift = winLsb - CSM_LUT_SHIFT;                 // R15
    assign pageIndex = 7'(hitOffset >> pageShift);             // R15

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_q <= '0;
        end else begin
            hit_q.lutValid    <= hitValid & selEn & ~selDirect;  // R12
            hit_q.directValid <= hitValid & selEn & selDirect;   // R12
            hit_q.index       <= pageIndex;
        end
    end

    assign hitResult = hit_q;

    // ========================================================================
    // Read data selection; anything unlisted, slot registers included, reads zero.
    logic [31:0] rdMux;
    logic [31:0] ack_d;
    logic [31:0] rdata_q;
    logic        ack_q;

    always_comb begin
        rdMux = 32'h00000000;                                                      // R20
        ack_d = 32'h00000000;
        if (cfgReq.addr[11:2] == CSM_OFF_SUBSYS_HDR[11:2]) begin
            rdMux = {16'h0000, CSM_SUBSYS_NEXT, CSM_SUBSYS_CAP_ID};               // R1
        end else if (cfgReq.addr[11:2] == CSM_OFF_SUBSYS_IDS[11:2]) begin
            rdMux = ids_q;                                                         // R2
        end else if (cfgReq.addr[11:2] == CSM_OFF_MSIX_CTL[11:2]) begin
            rdMux = {msix_q[31:30], 3'h0, 11'(MSIX_VECTORS - 1),                  // R4
                     CSM_MSIX_NEXT, CSM_MSIX_CAP_ID};                              // R3
        end else if (cfgReq.addr[11:2] == CSM_OFF_MSIX_TABLE[11:2]) begin
            rdMux = table_q;                                                       // R7
        end else if (cfgReq.addr[11:2] == CSM_OFF_MSIX_PEND[11:2]) begin
            rdMux = pend_q;                                                        // R8
        end else if (cfgReq.addr[11:2] == CSM_OFF_VENDOR_HDR[11:2]) begin
            rdMux = {CSM_VENDOR_LEN, CSM_VENDOR_NEXT, CSM_VENDOR_CAP_ID};          // R9
        end else if (cfgReq.addr[11:2] == CSM_OFF_BAR0[11:2]) begin
            rdMux = bar0_q;
        end else if (cfgReq.addr[11:2] == CSM_OFF_BAR2[11:2]) begin
            rdMux = g_pair[0].lo_q;
        end else if (cfgReq.addr[11:2] == CSM_OFF_BAR3[11:2]) begin
            rdMux = g_pair[0].hiRd;
        end else if (cfgReq.addr[11:2] == CSM_OFF_BAR4[11:2]) begin
            rdMux = g_pair[1].lo_q;
        end else if (cfgReq.addr[11:2] == CSM_OFF_BAR5[11:2]) begin
            rdMux = g_pair[1].hiRd;
        end
    end

    // Every access is answered one cycle later; write data reads back as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
            ack_q   <= 1'b0;
        end else begin
            ack_q   <= cfgReq.valid;
            rdata_q <= (cfgReq.valid & ~cfgReq.write) ? rdMux : ack_d;
        end
    end

    assign cfgAck   = ack_q;
    assign cfgRdata = rdata_q;

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic rdReq;
    assign rdReq = cfgReq.valid & ~cfgReq.write;

    property p_subsys_hdr;
        rdReq && cfgReq.addr == CSM_OFF_SUBSYS_HDR |=> cfgAck && cfgRdata == 32'h0000b00d;
    endproperty
    a_subsys_hdr: assert property (p_subsys_hdr) else $error("subsystem header wrong"); // R1

    property p_msix_hdr;
        rdReq && cfgReq.addr == CSM_OFF_MSIX_CTL |=> cfgRdata[15:0] == 16'hc811
            && cfgRdata[26:16] == 11'(MSIX_VECTORS - 1);
    endproperty
    a_msix_hdr: assert property (p_msix_hdr) else $error("msix header wrong"); // R3 R4

    property p_fn_mask;
        fnMask |-> vectorMasked == {MSIX_VECTORS{1'b1}};
    endproperty
    a_fn_mask: assert property (p_fn_mask) else $error("function mask ignored"); // R5

    property p_msix_gate;
        !$past(msixOn) && !msixOn |-> !msixSendAllowed && !intxBlocked;
    endproperty
    a_msix_gate: assert property (p_msix_gate) else $error("msix sent while off"); // R6

    property p_locators;
        rdReq && (cfgReq.addr == CSM_OFF_MSIX_TABLE || cfgReq.addr == CSM_OFF_MSIX_PEND)
            |=> cfgRdata[2:0] == 3'h0;
    endproperty
    a_locators: assert property (p_locators) else $error("locator index not BAR0"); // R7 R8

    property p_vendor_hdr;
        rdReq && cfgReq.addr == CSM_OFF_VENDOR_HDR |=> cfgRdata == 32'h00380009;
    endproperty
    a_vendor_hdr: assert property (p_vendor_hdr) else $error("vendor header wrong"); // R9

    property p_pair_off;
        g_pair[0].is64 && !g_pair[0].pairEn |-> winW[0].addrMask == 32'h0
            && winW[1].addrMask == 32'h0 && !winW[0].enable;
    endproperty
    a_pair_off: assert property (p_pair_off) else $error("disabled pair decodes"); // R18

    property p_hi32_type;
        rdReq && cfgReq.addr == CSM_OFF_BAR5 && !g_pair[1].is64 |=> cfgRdata[2:1] == 2'b00;
    endproperty
    a_hi32_type: assert property (p_hi32_type) else $error("upper type not fixed"); // R17

    property p_steer;
        hitValid && !hitPair && winW[0].enable && winW[0].direct
            |=> hitResult.directValid && !hitResult.lutValid;
    endproperty
    a_steer: assert property (p_steer) else $error("direct hit misrouted"); // R12

    property p_page_min;
        hitValid && !hitPair && winW[0].addrMask[20] && !winW[0].direct && winW[0].enable
            |=> hitResult.lutValid && hitResult.index == $past(hitOffset[19:13]);
    endproperty
    a_page_min: assert property (p_page_min) else $error("page index wrong"); // R15

    property p_reserved;
        rdReq && (cfgReq.addr == CSM_OFF_SLOT_CAP2 || cfgReq.addr == CSM_OFF_SLOT_CTL2)
            |=> cfgRdata == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved not zero"); // R20

    property p_bar0_type;
        bar0_q[1:0] == 2'b01 |-> !bar0Window.enable;
    endproperty
    a_bar0_type: assert property (p_bar0_type) else $error("reserved BAR0 type on"); // R10

    c_msix_on: cover property (msixSendAllowed ##1 !msixSendAllowed);
    c_pair64: cover property (hostWr && wrAddr == CSM_OFF_BAR2 ##1 g_pair[0].is64);
    c_lut_hit: cover property (hitResult.lutValid);

endmodule

// ---- design/csm_pkg.sv ----
// Package of offsets, field layouts, reset values and carrier types for the config bank.
package csm_pkg;

    // ========================================================================
    // Register byte offsets within configuration space.
    localparam logic [11:0] CSM_OFF_SLOT_CAP2   = 12'h09c;
    localparam logic [11:0] CSM_OFF_SLOT_CTL2   = 12'h0a0;
    localparam logic [11:0] CSM_OFF_SUBSYS_HDR  = 12'h0a4;
    localparam logic [11:0] CSM_OFF_SUBSYS_IDS  = 12'h0a8;
    localparam logic [11:0] CSM_OFF_MSIX_CTL    = 12'h0b0;
    localparam logic [11:0] CSM_OFF_MSIX_TABLE  = 12'h0b4;
    localparam logic [11:0] CSM_OFF_MSIX_PEND   = 12'h0b8;
    localparam logic [11:0] CSM_OFF_VENDOR_HDR  = 12'h0c8;
    localparam logic [11:0] CSM_OFF_BAR0        = 12'h0e4;
    localparam logic [11:0] CSM_OFF_BAR2        = 12'h0e8;
    localparam logic [11:0] CSM_OFF_BAR3        = 12'h0ec;
    localparam logic [11:0] CSM_OFF_BAR4        = 12'h0f0;
    localparam logic [11:0] CSM_OFF_BAR5        = 12'h0f4;

    // ========================================================================
    // Capability header contents.
    localparam logic [7:0]  CSM_SUBSYS_CAP_ID   = 8'h0d;
    localparam logic [7:0]  CSM_SUBSYS_NEXT     = 8'hb0;
    localparam logic [7:0]  CSM_MSIX_CAP_ID     = 8'h11;
    localparam logic [7:0]  CSM_MSIX_NEXT       = 8'hc8;
    localparam logic [7:0]  CSM_VENDOR_CAP_ID   = 8'h09;
    localparam logic [7:0]  CSM_VENDOR_NEXT     = 8'h00;
    localparam logic [15:0] CSM_VENDOR_LEN      = 16'h0038;

    // ========================================================================
    // Field positions and widths.
    localparam int CSM_FNMASK_BIT   = 30;
    localparam int CSM_MSIXEN_BIT   = 31;
    localparam int CSM_EN_BIT       = 31;
    localparam int CSM_PREF_BIT     = 3;
    localparam int CSM_MODE_BIT     = 4;
    localparam int CSM_DOM_LSB      = 5;
    localparam int CSM_SIZE_LSB     = 20;
    localparam int CSM_LUT_INDEX_W  = 7;
    localparam logic [5:0] CSM_LUT_SHIFT = 6'h07;
    localparam logic [5:0] CSM_NO_SIZE   = 6'h20;

    // ========================================================================
    // Type encodings.
    localparam logic [1:0] CSM_BAR0_32  = 2'b10;
    localparam logic [1:0] CSM_BAR0_64  = 2'b11;
    localparam logic [1:0] CSM_PAIR_64  = 2'b10;

    // ========================================================================
    // Reset values and write masks.
    localparam logic [31:0] CSM_RST_TABLE = 32'h0000fe00;
    localparam logic [31:0] CSM_RST_PEND  = 32'h0000fe10;
    localparam logic [31:0] CSM_RST_MSIX  = 32'h00000000;
    localparam logic [31:0] CSM_RST_BAR0  = 32'h00000002;
    localparam logic [31:0] CSM_RST_LO    = 32'hfff00000;
    localparam logic [31:0] CSM_RST_HI    = 32'h00000000;
    localparam logic [31:0] CSM_WM_MSIX   = 32'hc0000000;
    localparam logic [31:0] CSM_WM_BAR0   = 32'h00000007;
    localparam logic [31:0] CSM_WM_LO     = 32'hfff001fe;
    localparam logic [31:0] CSM_WM_HI32   = 32'hfff001e8;
    localparam logic [31:0] CSM_WM_HI64   = 32'hffffffff;
    localparam logic [31:0] CSM_WM_LOC    = 32'hfffffff8;
    localparam logic [31:0] CSM_WM_ALL    = 32'hffffffff;

    // ========================================================================
    // Carrier types.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  byteEn;
        logic [31:0] wdata;
    } csm_cfg_req_s;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [31:0] data;
    } csm_preload_s;

    typedef struct packed {
        logic        enable;
        logic        is64;
        logic        prefetch;
        logic        direct;
        logic [3:0]  domain;
        logic [31:0] addrMask;
    } csm_window_s;

    typedef struct packed {
        logic        lutValid;
        logic        directValid;
        logic [6:0]  index;
    } csm_hit_s;

endpackage

// ---- dv/csm_cfg_bank_bench.sv ----
// Self-checking bench for the configuration bank slice.
`timescale 1ns/1ps
module csm_cfg_bank_bench
    import csm_pkg::*;
;
    logic              clk, rst_n, cfgAck, msiEnable, hitValid, hitPair, ok;
    logic              vectorMask, vectorMasked, msixSendAllowed, intxBlocked;
    logic [31:0]       cfgRdata, hitOffset, q;
    csm_cfg_req_s      cfgReq;
    csm_preload_s      preload;
    csm_window_s       bar0Window;
    csm_window_s [3:0] pairWindows;
    csm_hit_s          hitResult;
    int                nFail, checkCount;
    logic [11:0]       offs [14] = '{12'h09c, 12'h0a0, 12'h0a4, 12'h0a8, 12'h0b0, 12'h0b4,
        12'h0b8, 12'h0c8, 12'h0e4, 12'h0e8, 12'h0ec, 12'h0f0, 12'h0f4, 12'h0ac};
    logic [31:0]       rstv [14] = '{32'h0, 32'h0, 32'h0000b00d, 32'h5a0a0a5a, 32'h0000c811,
        32'h0000fe00, 32'h0000fe10, 32'h00380009, 32'h2, 32'hfff00000, 32'h0, 32'hfff00000,
        32'h0, 32'h0};

    // ========================================================================
    // Bank under test and the host in front of it.
    csm_cfg_bank u_csm_cfg_bank (.clk, .rst_n, .cfgReq, .cfgAck, .cfgRdata, .preload,
        .msiEnable, .vectorMask, .msixSendAllowed, .intxBlocked, .vectorMasked, .bar0Window,
        .pairWindows, .hitValid, .hitPair, .hitOffset, .hitResult);
    csm_host_model u_csm_host_model (.clk, .cfgAck, .cfgRdata, .cfgReq);

    // Comparison, verdict and access helpers.
    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic acc(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
        u_csm_host_model.access(w, a, d, q, ok, be);
        if (!ok) begin
            check("cfgAck", 1, 0);
            stop_test();
        end
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        acc(1'b0, a, '0);
        check($sformatf("read %h", a), e, q);
    endtask
    // The offset lands on page 23h of a 1MB window; the result comes one edge later.
    task automatic hit(logic p, logic [8:0] e);
        @(posedge clk);
        hitValid  <= 1'b1;
        hitPair   <= p;
        hitOffset <= 32'h00046000;
        @(posedge clk);
        hitValid  <= 1'b0;
        hitOffset <= 32'hfffb9fff;
        #1;
        check("hitResult", {23'h0, e}, hitResult);
    endtask

    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Main sequence; preload, interrupt inputs and hits wait on an edge, register accesses go through the host.
    initial begin
        rst_n = 1'b0;
        preload = '0;
        {msiEnable, vectorMask, hitValid, hitPair, hitOffset} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 14; i++) rd(offs[i], rstv[i]);
        for (int i = 0; i < 8; i++) begin
            if (i != 4) begin
                acc(1'b1, offs[i], 32'hffffffff);
                rd(offs[i], rstv[i]);
            end
        end
        $display("test reset_and_readonly done");
        acc(1'b1, 12'h0b0, 32'h40000000);
        rd(12'h0b0, 32'h4000c811);
        check("irq", 3'b001, {msixSendAllowed, intxBlocked, vectorMasked});
        @(posedge clk);
        vectorMask <= 1'b1;
        acc(1'b1, 12'h0b0, 32'h80000000);
        check("irq", 3'b111, {msixSendAllowed, intxBlocked, vectorMasked});
        @(posedge clk);
        msiEnable  <= 1'b1;
        vectorMask <= 1'b0;
        #1;
        check("irq", 3'b000, {msixSendAllowed, intxBlocked, vectorMasked});
        for (int t = 0; t < 4; t++) begin
            acc(1'b1, 12'h0e4, 32'hfffffff8 | t);
            rd(12'h0e4, t);
            check("bar0", {t[1], t == 3}, {bar0Window.enable, bar0Window.is64});
        end
        acc(1'b1, 12'h0e4, 32'h00000004, 4'he);
        rd(12'h0e4, 32'h3);
        acc(1'b1, 12'h0e4, 32'h00000006, 4'h1);
        rd(12'h0e4, 32'h6);
        check("bar0", 3'b101, {bar0Window.enable, bar0Window.is64, bar0Window.prefetch});
        $display("test msix_and_bar0 done");
        for (int p = 0; p < 2; p++) begin
            logic [11:0] b;
            b = 12'h0e8 + 12'(8 * p);
            acc(1'b1, b, 32'h80f00000);
            rd(b, 32'h80f00000);
            check("mask", 32'h80f00000, pairWindows[2*p].addrMask);
            hit(p[0], 9'h123);
            acc(1'b1, b, 32'h80f00010);
            hit(p[0], 9'h0a3);
            acc(1'b1, b, 32'h00f00000);
            check("enable", 0, pairWindows[2*p].enable);
            hit(p[0], 9'h000);
            acc(1'b1, b + 12'h004, 32'hffffff7f);
            rd(b + 12'h004, 32'hfff00168);
            check("upper", 8'hbb, pairWindows[2*p+1][39:32]);
            check("umask", 32'hfff00000, pairWindows[2*p+1].addrMask);
            acc(1'b1, b, 32'h00000004);
            acc(1'b1, b + 12'h004, 32'h0);
            check("enable", 0, pairWindows[2*p].enable);
            acc(1'b1, b + 12'h004, 32'h80000000);
            rd(b + 12'h004, 32'h80000000);
            check("pair", 2'b11, {pairWindows[2*p].enable, pairWindows[2*p].is64});
        end
        $display("test bar_pairs done");
        @(posedge clk);
        preload <= '{1'b1, 12'h0a8, 32'h12345678};
        @(posedge clk);
        preload <= '{1'b1, 12'h0b4, 32'h0000abcf};
        @(posedge clk);
        preload <= '{1'b0, 12'hf4b, 32'hffff5430};
        rd(12'h0a8, 32'h12345678);
        rd(12'h0b4, 32'h0000abc8);
        $display("test preload done");
        stop_test();
    end
endmodule

// ---- dv/csm_host_model.sv ----
// Host model that issues configuration reads and writes toward the bank.
`timescale 1ns/1ps
module csm_host_model
    import csm_pkg::*;
(
    // Clock and answer.
    input  wire logic        clk,
    input  wire logic        cfgAck,
    input  wire logic [31:0] cfgRdata,
    // Request toward the bank.
    output csm_cfg_req_s     cfgReq
);
    // ========================================================================
    // Bus idles at zero until the first access.
    initial cfgReq = '0;

    // One access, held for the taking edge; a released bus shows inverted lines.
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q, output bit ok, input logic [3:0] be = 4'hf);
        csm_cfg_req_s r;
        if (w && d[8:5] > 4'hb) d[8:5] = 4'hb;
        r = '{1'b1, w, a, be, d};
        ok = 1'b0;
        q = '0;
        @(posedge clk);
        cfgReq <= r;
        @(posedge clk);
        r = ~r;
        r.valid = 1'b0;
        cfgReq <= r;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            ok = (cfgAck === 1'b1);
            q = cfgRdata;
            if (!ok) @(posedge clk);
        end
    endtask
endmodule
